// ===== gspi_pkg.sv
// constants shared by the gauge status-word serial block
// assumes one mclk domain for status logic and one sclk domain at the link
package gspi_pkg;
  localparam int unsigned SW_W      = 16;   // status and frame word width
  localparam int unsigned CNT_W     = 16;   // free-running link bit counter
  localparam int unsigned ACC_W     = 15;   // stall-detect accumulator width
  localparam int unsigned PRE_W     = 8;    // preload field width
  localparam int unsigned PRE_SHIFT = 4;    // preload scales by sixteen
  localparam int unsigned FRM_LOG2  = 4;    // frame unit is sixteen bits
  localparam int unsigned NFLAG     = 8;    // status flag bits 7..0
  localparam int unsigned NGAUGE    = 2;
  // status bit positions
  localparam int unsigned ST_SLICE_LSB = 8;
  localparam int unsigned ST_CAL       = 7;
  localparam int unsigned ST_SUPPLY    = 6;
  localparam int unsigned ST_MOVED0    = 4;
  localparam int unsigned ST_HOMING0   = 2;
  localparam int unsigned ST_OTEMP0    = 0;
  // accumulator slice windows
  localparam int unsigned SL_LOW_LSB  = 0;
  localparam int unsigned SL_MID_LSB  = 4;
  localparam int unsigned SL_HIGH_LSB = 8;
  localparam logic [1:0]  SL_SEL_LOW  = 2'h0;
  localparam logic [1:0]  SL_SEL_MID  = 2'h1;
endpackage : gspi_pkg

// ===== gspi_flag.sv
// one sticky status flag
// assumes set and clear pulses come from the mclk domain
`timescale 1ns/1ps
module gspi_flag (
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag_r
);
  import gspi_pkg::*;

  typedef struct packed {
    logic flag;
  } gspi_flag_st_t;

  gspi_flag_st_t st_r;
  gspi_flag_st_t st_nxt;

  // a set in the clearing cycle survives, so no event is lost
  always_comb begin
    st_nxt = st_r;
    if (clr) begin
      st_nxt.flag = 1'b0;
    end
    if (set) begin
      st_nxt.flag = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flag_r = st_r.flag;
endmodule : gspi_flag

// ===== gspi_accum.sv
// stall-detect integration accumulator and its status slice
// assumes step and integration strobes from the motion logic on mclk
`timescale 1ns/1ps
module gspi_accum (
  input  wire logic                       mclk,
  input  wire logic                       arst_n,
  input  wire logic                       clr,
  input  wire logic                       step_start,
  input  wire logic                       integ_en,
  input  wire logic                       integ_up,
  input  wire logic                       step_end,
  input  wire logic [gspi_pkg::PRE_W-1:0] preload,
  input  wire logic [1:0]                 slice_sel,
  output logic      [7:0]                 slice_r,
  output logic                            stall_r,
  output logic                            moving_r
);
  import gspi_pkg::*;

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] last;
    logic [7:0]       slice;
    logic             stall;
    logic             moving;
  } gspi_accum_st_t;

  gspi_accum_st_t st_r;
  gspi_accum_st_t st_nxt;

  // -(16*P)-1 equals the bitwise inverse of 16*P, so no adder is needed
  always_comb begin
    st_nxt        = st_r;
    st_nxt.stall  = 1'b0;
    st_nxt.moving = 1'b0;
    if (step_start) begin
      st_nxt.acc = ~(ACC_W'({preload, PRE_SHIFT'(0)}));
    end else if (integ_en) begin
      st_nxt.acc = integ_up ? st_r.acc + ACC_W'(1) : st_r.acc - ACC_W'(1);
    end
    // result holds in last once steps stop; the stall and moving verdicts pulse for one cycle only
    if (step_end) begin
      st_nxt.last   = st_r.acc;
      st_nxt.stall  = st_r.acc[ACC_W-1];
      st_nxt.moving = ~st_r.acc[ACC_W-1];
    end
    if (clr) begin
      st_nxt.last = '0;
    end
    case (slice_sel)
      SL_SEL_LOW: st_nxt.slice = st_nxt.last[SL_LOW_LSB +: 8];
      SL_SEL_MID: st_nxt.slice = st_nxt.last[SL_MID_LSB +: 8];
      default:    st_nxt.slice = {1'b0, st_nxt.last[ACC_W-1:SL_HIGH_LSB]};
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign slice_r  = st_r.slice;
  assign stall_r  = st_r.stall;
  assign moving_r = st_r.moving;
endmodule : gspi_accum

// ===== gspi_status.sv
// serial status-word slave of a dual gauge driver with sticky event flags
// assumes the link clock idles outside frames, shifts on sclk rising edges,
// and that the master leaves two mclk periods around chip select edges
`timescale 1ns/1ps
module gspi_status (
  input  wire logic                        mclk,
  input  wire logic                        arst_n,
  input  wire logic                        sclk,
  input  wire logic                        cs_n,
  input  wire logic                        si,
  output logic                             so,
  output logic                             so_oe,
  input  wire logic                        reset_pin_n,
  input  wire logic [gspi_pkg::PRE_W-1:0]  preload_field_value,
  input  wire logic                        slice_select_hi,
  input  wire logic                        slice_select_lo,
  input  wire logic                        step_start,
  input  wire logic                        integ_en,
  input  wire logic                        integ_up,
  input  wire logic                        step_end,
  input  wire logic                        homing_gauge,
  input  wire logic [gspi_pkg::NGAUGE-1:0] return_to_zero_on,
  input  wire logic [gspi_pkg::NGAUGE-1:0] return_to_zero_off,
  input  wire logic [gspi_pkg::NGAUGE-1:0] gauge_enable_command,
  input  wire logic                        cal_out_of_range,
  input  wire logic                        supply_uv,
  input  wire logic                        supply_ov,
  input  wire logic [gspi_pkg::NGAUGE-1:0] gauge_moved,
  input  wire logic [gspi_pkg::NGAUGE-1:0] gauge_overtemp,
  output logic      [gspi_pkg::SW_W-1:0]   cmd_word,
  output logic                             cmd_strobe,
  output logic                             stall_detected,
  output logic      [gspi_pkg::NGAUGE-1:0] gauge_off
);
  import gspi_pkg::*;

  // link-side state: shift register and free-running bit count
  typedef struct packed {
    logic [SW_W-1:0]  sh;
    logic [CNT_W-1:0] cnt;
  } gspi_link_st_t;

  // frame-open marker, forced clear whenever chip select is high
  typedef struct packed {
    logic open;
  } gspi_open_st_t;

  // mclk-side state
  typedef struct packed {
    logic              cs_s1;
    logic              cs_s2;
    logic              cs_d;
    logic              rp_s1;
    logic              rp_s2;
    logic              rp_d;
    logic [SW_W-1:0]   held;
    logic [CNT_W-1:0]  cnt_end;
    logic [SW_W-1:0]   cmd;
    logic              strobe;
    logic              oe;
    logic [NGAUGE-1:0] zero_seen;
    logic [NGAUGE-1:0] off;
  } gspi_core_st_t;

  gspi_link_st_t lk_r;
  gspi_link_st_t lk_nxt;
  gspi_open_st_t op_r;
  gspi_open_st_t op_nxt;
  gspi_core_st_t cr_r;
  gspi_core_st_t cr_nxt;

  logic              open_rst_n;
  logic              cs_rise;
  logic              rp_rise;
  logic [CNT_W-1:0]  frame_len;
  logic              frame_ok;
  logic [NFLAG-1:0]  fl_set;
  logic [NFLAG-1:0]  fl_clr;
  logic [NFLAG-1:0]  flags;
  logic [7:0]        slice;
  logic              stall_p;

  // ---------------- link domain ----------------
  // the first edge of a frame takes the frozen status word, later edges
  // shift on, so bits beyond sixteen are the input delayed by one word
  always_comb begin
    lk_nxt     = lk_r;
    lk_nxt.cnt = lk_r.cnt + CNT_W'(1);
    if (op_r.open) begin
      lk_nxt.sh = {lk_r.sh[SW_W-2:0], si};
    end else begin
      lk_nxt.sh = {cr_r.held[SW_W-2:0], si};
    end
    op_nxt      = op_r;
    op_nxt.open = 1'b1;
  end

  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // chip select high ends the frame without needing a clock edge
  assign open_rst_n = arst_n & ~cs_n;

  always_ff @(posedge sclk or negedge open_rst_n) begin
    if (!open_rst_n) begin
      op_r <= '0;
    end else begin
      op_r <= op_nxt;
    end
  end

  // before the first edge the word's MSB is shown straight from the snapshot
  assign so = op_r.open ? lk_r.sh[SW_W-1] : cr_r.held[SW_W-1];

  // ---------------- core domain ----------------
  assign cs_rise   = cr_r.cs_s2 & ~cr_r.cs_d;
  assign rp_rise   = cr_r.rp_s2 & ~cr_r.rp_d;
  // the link count is quiet once chip select is high, so reading it is safe
  assign frame_len = lk_r.cnt - cr_r.cnt_end;
  assign frame_ok  = cs_rise && (frame_len != '0)
                     && (frame_len[FRM_LOG2-1:0] == '0);

  // flag events; a set always overrides the clear of the same cycle
  always_comb begin
    fl_set = '0;
    fl_clr = '0;
    fl_set[ST_CAL]    = cal_out_of_range;
    fl_clr[ST_CAL]    = frame_ok;
    fl_set[ST_SUPPLY] = supply_uv | supply_ov;
    fl_clr[ST_SUPPLY] = frame_ok;
    for (int g = 0; g < NGAUGE; g++) begin
      fl_set[ST_MOVED0 + g]  = gauge_moved[g];
      fl_clr[ST_MOVED0 + g]  = frame_ok;
      fl_set[ST_HOMING0 + g] = return_to_zero_on[g];
      fl_clr[ST_HOMING0 + g] = return_to_zero_off[g]
                               | (frame_ok & cr_r.zero_seen[g]);
      fl_set[ST_OTEMP0 + g]  = gauge_overtemp[g];
      fl_clr[ST_OTEMP0 + g]  = gauge_enable_command[g];
    end
  end

  // invalid frames clear nothing, so the same flags go out again
  always_comb begin
    cr_nxt        = cr_r;
    cr_nxt.cs_s1  = cs_n;
    cr_nxt.cs_s2  = cr_r.cs_s1;
    cr_nxt.cs_d   = cr_r.cs_s2;
    cr_nxt.rp_s1  = reset_pin_n;
    cr_nxt.rp_s2  = cr_r.rp_s1;
    cr_nxt.rp_d   = cr_r.rp_s2;
    cr_nxt.strobe = 1'b0;
    cr_nxt.oe     = ~cr_r.cs_s2;
    if (cs_rise) begin
      cr_nxt.cnt_end = lk_r.cnt;
    end
    if (frame_ok) begin
      cr_nxt.cmd    = lk_r.sh;
      cr_nxt.strobe = 1'b1;
    end
    // snapshot tracks live status only while no frame is running
    if (cr_r.cs_s2 && !cs_rise) begin
      cr_nxt.held = {slice, flags};
    end
    for (int g = 0; g < NGAUGE; g++) begin
      if (stall_p && flags[ST_HOMING0 + g] && (homing_gauge == 1'(g))) begin
        cr_nxt.zero_seen[g] = 1'b1;
      end else if (!flags[ST_HOMING0 + g]) begin
        cr_nxt.zero_seen[g] = 1'b0;
      end
      if (gauge_enable_command[g]) begin
        cr_nxt.off[g] = 1'b0;
      end
      if (gauge_overtemp[g] || supply_ov) begin
        cr_nxt.off[g] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cr_r       <= '0;
      cr_r.cs_s1 <= 1'b1;
      cr_r.cs_s2 <= 1'b1;
      cr_r.cs_d  <= 1'b1;
      // reset pin idles high, so start its detector high to avoid a false rise
      cr_r.rp_s1 <= 1'b1;
      cr_r.rp_s2 <= 1'b1;
      cr_r.rp_d  <= 1'b1;
    end else begin
      cr_r <= cr_nxt;
    end
  end

  // one sticky cell per status flag
  for (genvar i = 0; i < NFLAG; i++) begin : g_flag
    gspi_flag u_flag (
      .mclk   (mclk),
      .arst_n (arst_n),
      .set    (fl_set[i]),
      .clr    (fl_clr[i]),
      .flag_r (flags[i])
    );
  end

  gspi_accum u_accum (
    .mclk       (mclk),
    .arst_n     (arst_n),
    .clr        (rp_rise),
    .step_start (step_start),
    .integ_en   (integ_en),
    .integ_up   (integ_up),
    .step_end   (step_end),
    .preload    (preload_field_value),
    .slice_sel  ({slice_select_hi, slice_select_lo}),
    .slice_r    (slice),
    .stall_r    (stall_p),
    .moving_r   ()
  );

  assign so_oe          = cr_r.oe;
  assign cmd_word       = cr_r.cmd;
  assign cmd_strobe     = cr_r.strobe;
  assign stall_detected = stall_p;
  assign gauge_off      = cr_r.off;
endmodule : gspi_status

// ===== gspi_status_chk.sv
// port checker for the gauge status-word slave
// assumes it is bound into gspi_status on the mclk domain
`timescale 1ns/1ps
module gspi_status_chk (
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        cs_n,
  input wire logic        so_oe,
  input wire logic        step_end,
  input wire logic        supply_ov,
  input wire logic [1:0]  gauge_enable_command,
  input wire logic [1:0]  gauge_overtemp,
  input wire logic [15:0] cmd_word,
  input wire logic        cmd_strobe,
  input wire logic        stall_detected,
  input wire logic [1:0]  gauge_off
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // frame end and command latch
  a_strobe_once: assert property (cmd_strobe |=> !cmd_strobe)
    else $error("command strobe wider than one cycle");
  a_strobe_idle: assert property (cmd_strobe |-> cs_n)
    else $error("command strobe inside a frame");
  a_word_cause: assert property ($changed(cmd_word) |-> cmd_strobe || $past(cmd_strobe))
    else $error("command word changed without strobe");
  // output driver follows chip select with a short sync lag
  a_oe_release: assert property ($rose(cs_n) |-> ##[1:4] !so_oe)
    else $error("serial output still driven after frame");
  a_oe_drive: assert property (!cs_n [*5] |-> so_oe)
    else $error("serial output not driven in frame");
  // driver shutdown on overvoltage and thermal faults, and stall report cause
  a_ov_off: assert property (supply_ov |-> ##[1:2] gauge_off == 2'h3)
    else $error("drivers not off after overvoltage");
  a_ot_off: assert property (gauge_overtemp[0] |-> ##[1:2] gauge_off[0])
    else $error("gauge 0 not off after overtemperature");
  a_off_hold: assert property (gauge_off[1] && !gauge_enable_command[1] |=> gauge_off[1])
    else $error("gauge 1 re-enabled without command");
  a_stall_cause: assert property (stall_detected |-> $past(step_end) || $past(step_end, 2))
    else $error("stall reported without step end");
  c_frame: cover property (cmd_strobe);
  c_stall: cover property (stall_detected);
  c_ov: cover property (gauge_off == 2'h3);
endmodule : gspi_status_chk

bind gspi_status gspi_status_chk u_gspi_status_chk (.mclk, .arst_n, .cs_n, .so_oe, .step_end,
  .supply_ov, .gauge_enable_command, .gauge_overtemp, .cmd_word, .cmd_strobe,
  .stall_detected, .gauge_off);

// ===== gspi_master.sv
// serial master model with a 15 ns link clock
// assumes so settles after each sclk rise; the clock stands still between frames
`timescale 1ns/1ps
module gspi_master (
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so
);
  // idle link: chip select high, clock low
  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
    si   = 1'h0;
  end
  // send n bits of d msb first, collect so into q
  task automatic xfer(input int n, input logic [31:0] d, output logic [31:0] q);
    q = 32'h0;
    #3;
    cs_n = 1'h0;
    #40;
    for (int i = n - 1; i >= 0; i--) begin
      si = d[i];
      #7.5;
      q = {q[30:0], so};
      sclk = 1'h1;
      #7.5;
      sclk = 1'h0;
    end
    #30;
    cs_n = 1'h1;
    si = ~si;  // released line must not keep its last level
    #50;
  endtask : xfer
endmodule : gspi_master

// ===== tb_gauge_spi_status_word.sv
// bench for the gauge status-word slave with a behavioural status model
// assumes gspi_master drives the link and the bench drives the motion side
`timescale 1ns/1ps
module tb_gauge_spi_status_word;
  import gspi_pkg::*;
  logic        mclk = 1'h0, arst_n = 1'h0, reset_pin_n = 1'h1, sclk, cs_n, si, so, so_oe;
  logic [7:0]  preload_field_value = 8'h00;
  logic        slice_select_hi = 1'h0, slice_select_lo = 1'h0, step_start = 1'h0;
  logic        integ_en = 1'h0, integ_up = 1'h0, step_end = 1'h0, homing_gauge = 1'h0;
  logic        cal_out_of_range = 1'h0, supply_uv = 1'h0, supply_ov = 1'h0;
  logic [1:0]  return_to_zero_on = 2'h0, return_to_zero_off = 2'h0;
  logic [1:0]  gauge_enable_command = 2'h0, gauge_moved = 2'h0, gauge_overtemp = 2'h0;
  logic [1:0]  gauge_off;
  logic [15:0] cmd_word;
  logic        cmd_strobe, stall_detected, st;
  logic [31:0] q, d;
  int          errors = 0, check_count = 0, acc, k, p;

  gspi_status u_gspi_status (.mclk, .arst_n, .sclk, .cs_n, .si, .so, .so_oe, .reset_pin_n,
    .preload_field_value, .slice_select_hi, .slice_select_lo, .step_start, .integ_en,
    .integ_up, .step_end, .homing_gauge, .return_to_zero_on, .return_to_zero_off,
    .gauge_enable_command, .cal_out_of_range, .supply_uv, .supply_ov, .gauge_moved,
    .gauge_overtemp, .cmd_word, .cmd_strobe, .stall_detected, .gauge_off);
  gspi_master u_gspi_master (.sclk, .cs_n, .si, .so);

  // core clock, 10 ns
  always #5 mclk = ~mclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // model of the status slice: 15-bit two's complement window
  function automatic logic [7:0] slice_of(input int a, input int sel);
    logic [14:0] v;
    v = a[14:0];
    return sel == 0 ? v[7:0] : sel == 1 ? v[11:4] : {1'h0, v[14:8]};
  endfunction : slice_of

  // hang guard: every test is short, so a fixed limit is enough
  initial begin
    #400000;
    errors++;
    $display("mismatch at %0t: run limit reached", $time);
    summarize();
  end

  // main sequence
  initial begin
    k = $urandom(39488);
    repeat (4) @(posedge mclk);
    arst_n <= 1'h1;
    repeat (3) @(posedge mclk);
    u_gspi_master.xfer(16, 32'h0, q);
    chk(q[15:0], 16'h0000, "reset word");
    chk(so_oe, 1'h0, "output off");
    $display("test reset done");
    @(posedge mclk);
    {supply_uv, supply_ov, cal_out_of_range} <= 3'h7;
    {gauge_moved, return_to_zero_on, gauge_overtemp} <= 6'h3F;
    @(posedge mclk);
    {supply_uv, supply_ov, cal_out_of_range} <= 3'h0;
    {gauge_moved, return_to_zero_on, gauge_overtemp} <= 6'h00;
    repeat (4) @(posedge mclk);
    chk(gauge_off, 2'h3, "drivers off");
    u_gspi_master.xfer(8, 32'h0, q);
    chk(q[7:0], 8'h00, "short frame head");
    u_gspi_master.xfer(16, 32'h0, q);
    chk(q[15:0], 16'h00FF, "word resent");
    u_gspi_master.xfer(16, 32'h0, q);
    chk(q[15:0], 16'h000F, "events cleared");
    @(posedge mclk);
    gauge_enable_command <= 2'h3;  // overtemp flags and driver shutdown clear again
    return_to_zero_off <= 2'h3;
    @(posedge mclk);
    gauge_enable_command <= 2'h0;
    return_to_zero_off <= 2'h0;
    u_gspi_master.xfer(16, 32'h0, q);
    chk(q[15:0], 16'h0000, "re-enabled word");
    chk(gauge_off, 2'h0, "drivers on");
    $display("test flags done");
    d = $urandom;
    u_gspi_master.xfer(32, d, q);
    chk(q, {16'h0000, d[31:16]}, "pass-through");
    chk(cmd_word, d[15:0], "command word");
    u_gspi_master.xfer(24, $urandom, q);
    chk(cmd_word, d[15:0], "odd frame ignored");
    $display("test framing done");
    // preload, integration and slice window per select code
    for (int t = 0; t < 8; t++) begin
      p = t < 2 ? 0 : t < 4 ? 255 : $urandom_range(255);
      k = t == 1 ? 20 : $urandom_range(15, 1);
      @(posedge mclk);
      preload_field_value <= p[7:0];
      {slice_select_hi, slice_select_lo} <= t[1:0];
      // steps 2 and 3 home gauge 0 and gauge 1 into a stall
      homing_gauge <= t[0];
      return_to_zero_on <= t == 2 ? 2'h1 : t == 3 ? 2'h2 : 2'h0;
      step_start <= 1'h1;
      @(posedge mclk);
      step_start <= 1'h0;
      return_to_zero_on <= 2'h0;
      integ_en <= 1'h1;
      integ_up <= (t != 5);
      repeat (k) @(posedge mclk);
      integ_en <= 1'h0;
      step_end <= 1'h1;
      @(posedge mclk);
      step_end <= 1'h0;
      st = 1'h0;
      repeat (3) begin
        @(negedge mclk);
        st = st | stall_detected;
      end
      acc = -16 * p - 1 + (t == 5 ? -k : k);
      chk(st, acc < 0, "stall decision");
      u_gspi_master.xfer(16, 32'h0, q);
      chk(q[15:8], slice_of(acc, t % 4), "slice");
      chk(q[3:2], t == 2 ? 2'h1 : t == 3 ? 2'h2 : 2'h0, "homing until stall");
      u_gspi_master.xfer(16, 32'h0, q);
      chk(q[15:8], slice_of(acc, t % 4), "slice kept");
      chk(q[3:2], 2'h0, "homing cleared");
    end
    @(posedge mclk);
    reset_pin_n <= 1'h0;
    repeat (3) @(posedge mclk);
    reset_pin_n <= 1'h1;
    repeat (5) @(posedge mclk);
    u_gspi_master.xfer(16, 32'h0, q);
    chk(q[15:8], 8'h00, "slice after reset pin");
    $display("test accumulator done");
    summarize();
  end
endmodule : tb_gauge_spi_status_word
